// ---- acr_pkg.sv ----
// package: register map, field layout and bus structs of the converter setup
`default_nettype none
package acr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CHANNEL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REF     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL0   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CLKDIV  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_FLAG    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RESULT  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // field widths and positions
  localparam int unsigned CH_W     = 6;
  localparam int unsigned POSITIVE_REF_SELECT_W   = 3;
  localparam int unsigned DIV_W    = 7;
  localparam int unsigned RES_W    = 12;
  localparam int unsigned PAIR_W   = 16;
  localparam int unsigned JUST_SH  = PAIR_W - RES_W;
  localparam int unsigned NEGATIVE_REF_SELECT_POS = 4;
  localparam int unsigned CS_POS   = 0;
  localparam int unsigned FRM_POS  = 1;
  localparam int unsigned IE_POS   = 0;
  localparam int unsigned PERIPHERAL_INT_ENABLE_POS = 1;
  localparam int unsigned GIE_POS  = 2;
  localparam int unsigned FLAG_POS = 0;
  localparam int unsigned ST_CH_POS   = 0;
  localparam int unsigned ST_POSITIVE_REF_SELECT_POS = 8;
  localparam int unsigned ST_NEGATIVE_REF_SELECT_POS = 11;
  localparam int unsigned ST_RUN_POS  = 12;
  localparam int unsigned ST_CLK_POS  = 13;

  ////////////////////////////////////////////////////////////////////////////
  // positive reference codes
  typedef enum logic [POSITIVE_REF_SELECT_W-1:0] {
    POSITIVE_REF_SELECT_SUPPLY  = 3'h0,
    POSITIVE_REF_SELECT_EXT_PIN = 3'h1,
    POSITIVE_REF_SELECT_FIX_1V  = 3'h2,
    POSITIVE_REF_SELECT_FIX_2V  = 3'h3,
    POSITIVE_REF_SELECT_FIX_4V  = 3'h4
  } acr_positive_ref_select_t;

  // reset values
  localparam logic [CH_W-1:0]  RST_CH  = 6'h00;
  localparam logic [DIV_W-1:0] RST_DIV = 7'h00;
  localparam logic [RES_W-1:0] RST_RES = 12'h000;

  // responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite carriers
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0]        awprot;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic [2:0]        arprot;
    logic              rready;
  } acr_axil_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } acr_axil_rsp_t;

  // settings applied to the analog side
  typedef struct packed {
    logic [CH_W-1:0] channel;
    acr_positive_ref_select_t       positive_ref_select;
    logic            negative_ref_select_pin;
  } acr_analog_cfg_t;

endpackage : acr_pkg
`default_nettype wire

// ---- acr_top.sv ----
// converter setup block: channel, references, conversion clock, flag, result
`default_nettype none
module acr_top
  import acr_pkg::*;
(
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // register bus
  input  wire acr_pkg::acr_axil_req_t  axil_req,
  output var  acr_pkg::acr_axil_rsp_t  axil_rsp,
  // converter side
  input  wire logic                    rc_osc_clk,
  input  wire logic                    conv_done,
  input  wire logic [acr_pkg::RES_W-1:0] conv_result,
  output var  acr_pkg::acr_analog_cfg_t analog_cfg,
  output var  logic                    conv_clk,
  output logic                         conv_tick,
  // system power state
  input  wire logic                    sleep_mode,
  output logic                         wake_req,
  output logic                         irq
);
  import acr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [CH_W-1:0]  channel_q;
  acr_positive_ref_select_t        positive_ref_select_q;
  logic             negative_ref_select_q;
  logic             cs_q;
  logic             frm_q;
  logic [DIV_W-1:0] div_q;
  logic             flag_q;
  logic             ie_q;
  logic             peripheral_int_enable_q;
  logic             gie_q;
  logic [RES_W-1:0] result_q;

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture
  logic              aw_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_have_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              do_write;

  // address and data may arrive in either order
  // awready and wready stay low while a write response still waits, yet the capture registers still load
  assign axil_rsp.awready = !aw_have_q && !bvalid_q;
  assign axil_rsp.wready  = !w_have_q && !bvalid_q;
  assign axil_rsp.bvalid  = bvalid_q;
  assign axil_rsp.bresp   = bresp_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (axil_req.awvalid && !aw_have_q) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= axil_req.awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (axil_req.wvalid && !w_have_q) begin
      w_have_q <= 1'b1;
      w_data_q <= axil_req.wdata;
      w_strb_q <= axil_req.wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux, also used to merge byte strobes on writes
  logic [PAIR_W-1:0] pair_view;
  logic              conv_clk_q;
  acr_analog_cfg_t   applied_q;
  logic              run_ok;

  always_comb begin
    if (frm_q) begin
      pair_view = {{JUST_SH{1'b0}}, result_q};
    end else begin
      pair_view = {result_q, {JUST_SH{1'b0}}};
    end
  end

  function automatic logic [DATA_W:0] read_word(input logic [ADDR_W-1:0] a);
    logic [DATA_W:0] r;
    r = '0;
    unique case (a)
      OFS_CHANNEL: r[CH_W-1:0] = channel_q;
      OFS_REF: begin
        r[POSITIVE_REF_SELECT_W-1:0] = positive_ref_select_q;
        r[NEGATIVE_REF_SELECT_POS]   = negative_ref_select_q;
      end
      OFS_CTRL0: begin
        r[CS_POS]  = cs_q;
        r[FRM_POS] = frm_q;
      end
      OFS_CLKDIV: r[DIV_W-1:0] = div_q;
      OFS_FLAG:   r[FLAG_POS] = flag_q;
      OFS_ENABLE: begin
        r[IE_POS]   = ie_q;
        r[PERIPHERAL_INT_ENABLE_POS] = peripheral_int_enable_q;
        r[GIE_POS]  = gie_q;
      end
      OFS_RESULT: r[PAIR_W-1:0] = pair_view;
      OFS_STATUS: begin
        r[ST_CH_POS +: CH_W]     = applied_q.channel;
        r[ST_POSITIVE_REF_SELECT_POS +: POSITIVE_REF_SELECT_W] = applied_q.positive_ref_select;
        r[ST_NEGATIVE_REF_SELECT_POS]           = applied_q.negative_ref_select_pin;
        r[ST_RUN_POS]            = run_ok;
        r[ST_CLK_POS]            = conv_clk_q;
      end
      default: r[DATA_W] = 1'b1;
    endcase
    return r;
  endfunction : read_word

  logic [DATA_W:0]   wr_old;
  logic [DATA_W-1:0] wr_mask;
  logic [DATA_W-1:0] wr_val;
  logic              wr_hit;

  always_comb begin
    wr_old = read_word(aw_addr_q);
    wr_hit = do_write && !wr_old[DATA_W];
    for (int i = 0; i < 4; i++) begin
      wr_mask[i*8 +: 8] = {8{w_strb_q[i]}};
    end
    wr_val = (wr_old[DATA_W-1:0] & ~wr_mask) | (w_data_q & wr_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_old[DATA_W] ? RESP_SLVERR : RESP_OKAY;
    end else if (axil_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_q <= RST_CH;
      positive_ref_select_q    <= POSITIVE_REF_SELECT_SUPPLY;
      negative_ref_select_q    <= 1'b0;
      div_q     <= RST_DIV;
    end else if (wr_hit) begin
      unique case (aw_addr_q)
        OFS_CHANNEL: channel_q <= wr_val[CH_W-1:0];
        OFS_REF: begin
          if (wr_val[POSITIVE_REF_SELECT_W-1:0] <= POSITIVE_REF_SELECT_FIX_4V) begin
            positive_ref_select_q <= acr_positive_ref_select_t'(wr_val[POSITIVE_REF_SELECT_W-1:0]);
          end
          negative_ref_select_q <= wr_val[NEGATIVE_REF_SELECT_POS];
        end
        OFS_CLKDIV: div_q <= wr_val[DIV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_q   <= 1'b0;
      frm_q  <= 1'b0;
      ie_q   <= 1'b0;
      peripheral_int_enable_q <= 1'b0;
      gie_q  <= 1'b0;
    end else if (wr_hit && aw_addr_q == OFS_CTRL0) begin
      cs_q  <= wr_val[CS_POS];
      frm_q <= wr_val[FRM_POS];
    end else if (wr_hit && aw_addr_q == OFS_ENABLE) begin
      ie_q   <= wr_val[IE_POS];
      peripheral_int_enable_q <= wr_val[PERIPHERAL_INT_ENABLE_POS];
      gie_q  <= wr_val[GIE_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done flag: hardware sets, software clears by writing zero; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (conv_done) begin
      flag_q <= 1'b1;
    end else if (wr_hit && aw_addr_q == OFS_FLAG && !wr_val[FLAG_POS]) begin
      flag_q <= 1'b0;
    end
  end

  // result: converter load beats software write, both right justified
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= RST_RES;
    end else if (conv_done) begin
      result_q <= conv_result;
    end else if (wr_hit && aw_addr_q == OFS_RESULT) begin
      result_q <= wr_val[RES_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic [DATA_W:0]   rd_word;

  assign axil_rsp.arready = !rvalid_q;
  assign axil_rsp.rvalid  = rvalid_q;
  assign axil_rsp.rdata   = rdata_q;
  assign axil_rsp.rresp   = rresp_q;
  // evaluated in a process so that register changes reach the read data
  // even while the read address stands still
  always_comb begin
    rd_word = read_word(axil_req.araddr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (axil_req.arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word[DATA_W-1:0];
      rresp_q  <= rd_word[DATA_W] ? RESP_SLVERR : RESP_OKAY;
    end else if (axil_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock: divided system clock or the RC oscillator
  logic [DIV_W-1:0] div_cnt_q;
  logic             div_clk_q;
  logic             rc_q;

  // without the RC source nothing runs while asleep
  assign run_ok = cs_q || !sleep_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= '0;
      div_clk_q <= 1'b0;
    end else if (!run_ok || cs_q) begin
      div_cnt_q <= '0;
    end else if (div_cnt_q >= div_q) begin
      div_cnt_q <= '0;
      div_clk_q <= !div_clk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_q       <= 1'b0;
      conv_clk_q <= 1'b0;
    end else begin
      rc_q       <= rc_osc_clk;
      conv_clk_q <= cs_q ? rc_q : div_clk_q;
    end
  end

  assign conv_clk = conv_clk_q;

  // rising edge of the selected conversion clock
  logic conv_clk_d1_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_clk_d1_q <= 1'b0;
    end else begin
      conv_clk_d1_q <= conv_clk_q;
    end
  end

  // one system clock long; the analog settings move over on it
  assign conv_tick = conv_clk_q && !conv_clk_d1_q;

  ////////////////////////////////////////////////////////////////////////////
  // analog settings move over only on conversion clock edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_q <= '{channel: RST_CH, positive_ref_select: POSITIVE_REF_SELECT_SUPPLY, negative_ref_select_pin: 1'b0};
    end else if (conv_tick) begin
      applied_q.channel  <= channel_q;
      applied_q.positive_ref_select     <= positive_ref_select_q;
      applied_q.negative_ref_select_pin <= negative_ref_select_q;
    end
  end

  assign analog_cfg = applied_q;

  ////////////////////////////////////////////////////////////////////////////
  // wake and interrupt request
  // wake ignores the global enable so sleep can end without vectoring
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_req <= 1'b0;
      irq      <= 1'b0;
    end else begin
      wake_req <= sleep_mode && flag_q && ie_q && peripheral_int_enable_q;
      irq      <= flag_q && ie_q && peripheral_int_enable_q && gie_q;
    end
  end

endmodule : acr_top
`default_nettype wire

// ---- acr_top_checker.sv ----
// checker: bus, conversion clock and flag relations at the block ports
`default_nettype none
module acr_top_checker
  import acr_pkg::*;
(
  // clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // register bus
  input wire acr_pkg::acr_axil_req_t     axil_req,
  input wire acr_pkg::acr_axil_rsp_t     axil_rsp,
  // converter side
  input wire logic                       rc_osc_clk,
  input wire logic                       conv_done,
  input wire logic [acr_pkg::RES_W-1:0]  conv_result,
  input wire acr_pkg::acr_analog_cfg_t   analog_cfg,
  input wire logic                       conv_clk,
  input wire logic                       conv_tick,
  // power state
  input wire logic                       sleep_mode,
  input wire logic                       wake_req,
  input wire logic                       irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_both;
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
  endsequence
  sequence s_sleep_irq;
    sleep_mode ##1 irq;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_wr_both |-> ##2 axil_rsp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (axil_req.arvalid && axil_rsp.arready
                                  |=> axil_rsp.rvalid)
    else $error("read response late");
  a_resp_hold: assert property (axil_rsp.bvalid && !axil_req.bready
                                |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (axil_rsp.rvalid && !axil_req.rready
                                 |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
    else $error("read data dropped early");
  a_ready_refuse: assert property (axil_rsp.bvalid |-> !axil_rsp.awready
                                   && !axil_rsp.wready)
    else $error("write accepted while response pending");
  a_tick_edge: assert property (
    $rose(conv_clk) |-> ##[0:1] conv_tick ##1 !conv_tick)
    else $error("conversion tick missing or too long");
  a_cfg_on_tick: assert property (
    !conv_tick |=> $stable(analog_cfg))
    else $error("analog settings changed between ticks");
  a_wake_awake: assert property (!sleep_mode |=> !wake_req)
    else $error("wake request while awake");
  a_sleep_wake: assert property (s_sleep_irq |-> wake_req)
    else $error("pending interrupt in sleep gave no wake");
  a_flag_sticky: assert property (irq && !axil_rsp.bvalid |=> irq)
    else $error("flag cleared without a write");
endmodule : acr_top_checker

bind acr_top acr_top_checker acr_top_checker_i (
  .aclk, .aresetn, .axil_req, .axil_rsp, .rc_osc_clk, .conv_done,
  .conv_result, .analog_cfg, .conv_clk, .conv_tick, .sleep_mode,
  .wake_req, .irq
);
`default_nettype wire

// ---- acr_top_tb_top.sv ----
// testbench: registers, clock selection, done flag and result format
`default_nettype none
module acr_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import acr_pkg::*;

  logic             aclk;
  logic             aresetn;
  acr_axil_req_t    req;
  acr_axil_rsp_t    rsp;
  logic             rc_osc_clk;
  logic             conv_done;
  logic [RES_W-1:0] conv_result;
  acr_analog_cfg_t  cfg;
  logic             conv_clk;
  logic             conv_tick;
  logic             sleep_mode;
  logic             wake_req;
  logic             irq;
  logic [1:0]       rc_cnt;
  int               err_total;
  int               n_checks;

  acr_top acr_top_i (
    .aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
    .rc_osc_clk(rc_osc_clk), .conv_done(conv_done),
    .conv_result(conv_result), .analog_cfg(cfg), .conv_clk(conv_clk),
    .conv_tick(conv_tick), .sleep_mode(sleep_mode), .wake_req(wake_req),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // rc oscillator stand-in: period of six system clocks
  always @(posedge aclk) begin
    rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    if (rc_cnt == 2'h2) rc_osc_clk <= ~rc_osc_clk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    acr_axil_rsp_t s;
    logic [1:0]    r;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.bready  <= 1'b1;
    for (int c = 0; c < 40; c++) begin
      #1 s = rsp;
      @(posedge aclk);
      if (s.awready) req.awvalid <= 1'b0;
      if (s.wready) req.wvalid <= 1'b0;
      if (s.bvalid) begin
        r = s.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
    chk(32'(r), 32'(er));
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    acr_axil_rsp_t s;
    logic [31:0]   d;
    logic [1:0]    r;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (int c = 0; c < 40; c++) begin
      #1 s = rsp;
      @(posedge aclk);
      if (s.arready) req.arvalid <= 1'b0;
      if (s.rvalid) begin
        d = s.rdata;
        r = s.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask : rdc

  // cycles between the second and third rise of conv_clk, 0 if it stalls
  task automatic per(output int v);
    int   c  = 0;
    int   k  = 0;
    int   t0 = 0;
    logic p  = conv_clk;
    while (k < 3 && c < 1000) begin
      @(posedge aclk);
      #1;
      c++;
      if (conv_clk && !p) k++;
      if (conv_clk && !p && k == 2) t0 = c;
      p = conv_clk;
    end
    v = (k == 3) ? c - t0 : 0;
  endtask : per

  task automatic pulse(input logic [11:0] r);
    @(posedge aclk);
    conv_done   <= 1'b1;
    conv_result <= r;
    @(posedge aclk);
    conv_done <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_cfg;
    int v;
    rdc(OFS_CHANNEL, 32'h0, RESP_OKAY);
    rdc(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    // park on grounded channel 0 to drain the hold capacitor first
    wr(OFS_CHANNEL, 32'h0, RESP_OKAY);
    per(v);
    chk(32'(cfg.channel), 32'h0);
    wr(OFS_CHANNEL, 32'h0000_002A, RESP_OKAY);
    for (int p = 0; p < 5; p++) begin
      wr(OFS_REF, 32'(p) | 32'h0000_0010, RESP_OKAY);
      per(v);
      chk(32'(v), 32'h2);
      chk(32'(cfg), {22'h0, 6'h2A, 3'(p), 1'b1});
    end
    wr(OFS_REF, 32'h0000_0005, RESP_OKAY);
    per(v);
    chk(32'(cfg), {22'h0, 6'h2A, 3'h4, 1'b0});
  endtask : t_cfg

  task automatic t_div;
    int v;
    int nv[6] = '{1, 2, 3, 4, 63, 127};
    foreach (nv[i]) begin
      wr(OFS_CLKDIV, 32'(nv[i]), RESP_OKAY);
      per(v);
      chk(32'(v), 32'(2 * (nv[i] + 1)));
    end
    wr(OFS_CLKDIV, 32'h0, RESP_OKAY);
  endtask : t_div

  task automatic t_rc;
    int v;
    wr(OFS_CTRL0, 32'h1, RESP_OKAY);
    per(v);
    chk(32'(v), 32'h6);
    @(posedge aclk);
    sleep_mode <= 1'b1;
    per(v);
    chk(32'(v), 32'h6);
    wr(OFS_CTRL0, 32'h0, RESP_OKAY);
    per(v);
    chk(32'(v), 32'h0);
    @(posedge aclk);
    sleep_mode <= 1'b0;
  endtask : t_rc

  task automatic t_flag;
    pulse(12'hABC);
    rdc(OFS_FLAG, 32'h1, RESP_OKAY);
    chk(32'(irq), 32'h0);
    wr(OFS_ENABLE, 32'h7, RESP_OKAY);
    rdc(OFS_RESULT, 32'h0000_ABC0, RESP_OKAY);
    chk(32'(irq), 32'h1);
    wr(OFS_CTRL0, 32'h2, RESP_OKAY);
    rdc(OFS_RESULT, 32'h0000_0ABC, RESP_OKAY);
    wr(OFS_FLAG, 32'h1, RESP_OKAY);
    rdc(OFS_FLAG, 32'h1, RESP_OKAY);
    wr(OFS_FLAG, 32'h0, RESP_OKAY);
    rdc(OFS_FLAG, 32'h0, RESP_OKAY);
    chk(32'(irq), 32'h0);
    wr(OFS_ENABLE, 32'h3, RESP_OKAY);
    sleep_mode <= 1'b1;
    pulse(12'h5A5);
    chk({30'h0, wake_req, irq}, 32'h2);
    wr(OFS_ENABLE, 32'h7, RESP_OKAY);
    @(posedge aclk);
    #1;
    chk({30'h0, wake_req, irq}, 32'h3);
    @(posedge aclk);
    sleep_mode <= 1'b0;
    wr(OFS_FLAG, 32'h0, RESP_OKAY);
  endtask : t_flag

  task automatic t_result;
    wr(OFS_CTRL0, 32'h0, RESP_OKAY);
    wr(OFS_RESULT, 32'h0000_0123, RESP_OKAY);
    rdc(OFS_RESULT, 32'h0000_1230, RESP_OKAY);
    wr(OFS_CTRL0, 32'h2, RESP_OKAY);
    rdc(OFS_RESULT, 32'h0000_0123, RESP_OKAY);
  endtask : t_result

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    req         = '0;
    req.wstrb   = 4'hF;
    rc_osc_clk  = 1'b0;
    rc_cnt      = 2'h0;
    conv_done   = 1'b0;
    conv_result = 12'h000;
    sleep_mode  = 1'b0;
    err_total   = 0;
    n_checks    = 0;
    aresetn     = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_cfg;
    t_div;
    t_rc;
    t_flag;
    t_result;
    finish_test;
  end
endmodule : acr_top_tb_top
`default_nettype wire
